// File: dcs_ctrl_model.sv
// network controller model sending startup record one
// assumes the record port of dcs_door_comm on clk_i
`timescale 1ns/1ps
`default_nettype none
module dcs_ctrl_model
(
    // clock
    input  wire logic       clk_i,
    // record port
    output var  logic       rec_start_o,
    output var  logic       rec_valid_o,
    output var  logic [7:0] rec_data_o
);
    // idle port at start
    initial
    begin
        rec_start_o = 1'h0;
        rec_valid_o = 1'h0;
        rec_data_o  = 8'h5a;
    end

    // start pulse, then eight bytes with gap idle cycles before each
    task automatic send_rec(input logic [7:0] b0, input int gap);
        @(posedge clk_i) #1;
        rec_start_o = 1'h1;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_i) #1;
            rec_start_o = 1'h0;
            repeat (gap)
            begin
                rec_valid_o = 1'h0;
                rec_data_o  = ~rec_data_o; // released bus wanders
                @(posedge clk_i) #1;
            end
            rec_valid_o = 1'h1;
            rec_data_o  = (i == 0) ? b0 : 8'h00;
        end
        @(posedge clk_i) #1;
        rec_valid_o = 1'h0;
        rec_data_o  = ~rec_data_o;
    endtask : send_rec

    // start pulse, nb bytes, then a fresh start that cuts the record short
    task automatic send_cut(input int nb);
        @(posedge clk_i) #1;
        rec_start_o = 1'h1;
        for (int i = 0; i < nb; i++)
        begin
            @(posedge clk_i) #1;
            rec_start_o = 1'h0;
            rec_valid_o = 1'h1;
            rec_data_o  = 8'h11;
        end
        @(posedge clk_i) #1;
        rec_valid_o = 1'h0;
        rec_start_o = 1'h1;
        @(posedge clk_i) #1;
        rec_start_o = 1'h0;
    endtask : send_cut
endmodule : dcs_ctrl_model
`default_nettype wire

// File: dcs_door_comm.sv
// startup record intake, internal bus settings and door state relays
// assumes inputs synchronous to clk_i and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module dcs_door_comm
(
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        srst_i,
    // startup record from the network controller
    input  wire logic                        rec_start_i,
    input  wire logic                        rec_valid_i,
    input  wire logic [7:0]                  rec_data_i,
    // record status
    output logic                             rec_done_o,
    output logic                             rec_error_o,
    // internal bus settings
    output logic                             bus_exchange_en_o,
    output logic      [3:0]                  baud_code_o,
    output logic      [dcs_pkg::DIV_W-1:0]   baud_div_o,
    output logic                             baud_tick_o,
    // door events from the drive
    input  wire logic                        drive_start_i,
    input  wire logic                        close_reached_i,
    input  wire logic                        push_i,
    input  wire logic                        open_pos_i,
    // sensor test
    input  wire logic                        sensor_test_active_i,
    input  wire logic                        sensor_test_output_i,
    input  wire logic [1:0]                  sensor_config_parameter_i,
    // relays, high closes the contact
    output logic                             relay_closed_o,
    output logic                             relay_open_o
);

    // record intake state
    dcs_pkg::dcs_rec_state_t           rec_st_r, rec_st_nxt;
    logic [dcs_pkg::REC_AW-1:0]        wr_idx_r, wr_idx_nxt;
    logic                              done_r, done_nxt;
    logic                              err_r, err_nxt;
    logic                              mem_wr_en;
    logic [7:0]                        cfg_byte;

    // bus settings state
    logic                              xchg_en_r, xchg_en_nxt;
    logic [3:0]                        baud_r, baud_nxt;
    logic [dcs_pkg::DIV_W-1:0]         div_r, div_nxt;
    logic [dcs_pkg::DIV_W-1:0]         bcnt_r, bcnt_nxt;
    logic                              tick_r, tick_nxt;

    // door state
    dcs_pkg::dcs_door_state_t          door_r, door_nxt;
    logic                              rly_cl_r, rly_cl_nxt;
    logic                              rly_op_r, rly_op_nxt;

    // record byte store
    dcs_rec_mem dcs_rec_mem_inst
    (
        .clk_i     (clk_i),
        .wr_en_i   (mem_wr_en),
        .wr_addr_i (wr_idx_r),
        .wr_data_i (rec_data_i),
        .rd_addr_i (dcs_pkg::REC_CFG_IDX),
        .rd_data_o (cfg_byte)
    );

    // bytes are stored only while a record is being filled
    assign mem_wr_en = rec_valid_i && !rec_start_i && (rec_st_r == dcs_pkg::REC_FILL);

    // record intake sequencing
    always_comb
    begin
        rec_st_nxt = rec_st_r;
        wr_idx_nxt = wr_idx_r;
        done_nxt   = 1'b0;
        err_nxt    = 1'b0;
        if (rec_start_i)
        begin
            // a new connection restarts the record
            err_nxt    = (rec_st_r == dcs_pkg::REC_FILL) && (wr_idx_r != '0);
            rec_st_nxt = dcs_pkg::REC_FILL;
            wr_idx_nxt = '0;
        end
        else
        begin
            unique case (rec_st_r)
                dcs_pkg::REC_IDLE:
                begin
                    rec_st_nxt = dcs_pkg::REC_IDLE;
                end
                dcs_pkg::REC_FILL:
                begin
                    if (rec_valid_i)
                    begin
                        // eight bytes make one record
                        if (wr_idx_r == dcs_pkg::REC_LAST_IDX)
                        begin
                            rec_st_nxt = dcs_pkg::REC_READ;
                        end
                        wr_idx_nxt = wr_idx_r + 3'h1;
                    end
                end
                dcs_pkg::REC_READ:
                begin
                    rec_st_nxt = dcs_pkg::REC_APPLY;
                end
                dcs_pkg::REC_APPLY:
                begin
                    rec_st_nxt = dcs_pkg::REC_IDLE;
                    done_nxt   = 1'b1;
                    err_nxt    = cfg_byte[dcs_pkg::BAUD_MSB:dcs_pkg::BAUD_LSB]
                                 > dcs_pkg::BAUD_MAX;
                end
                default:
                begin
                    rec_st_nxt = dcs_pkg::REC_IDLE;
                end
            endcase
        end
    end

    // record intake registers
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rec_st_r <= dcs_pkg::REC_IDLE;
            wr_idx_r <= '0;
            done_r   <= 1'b0;
            err_r    <= 1'b0;
        end
        else
        begin
            rec_st_r <= rec_st_nxt;
            wr_idx_r <= wr_idx_nxt;
            done_r   <= done_nxt;
            err_r    <= err_nxt;
        end
    end

    // settings decode and bit rate tick
    always_comb
    begin
        xchg_en_nxt = xchg_en_r;
        baud_nxt    = baud_r;
        div_nxt     = div_r;
        tick_nxt    = 1'b0;
        bcnt_nxt    = bcnt_r;
        if (rec_st_r == dcs_pkg::REC_APPLY && !rec_start_i)
        begin
            // exchange enable from bit zero, held until next record
            xchg_en_nxt = cfg_byte[dcs_pkg::XCHG_EN_BIT];
            // illegal rate codes keep the previous rate
            if (cfg_byte[dcs_pkg::BAUD_MSB:dcs_pkg::BAUD_LSB] <= dcs_pkg::BAUD_MAX)
            begin
                baud_nxt = cfg_byte[dcs_pkg::BAUD_MSB:dcs_pkg::BAUD_LSB];
                div_nxt  = dcs_pkg::baud_div(baud_nxt);
            end
        end
        // bit clock stops while exchange is off
        if (!xchg_en_r)
        begin
            bcnt_nxt = '0;
        end
        else if (bcnt_r >= div_r - 14'h1)
        begin
            bcnt_nxt = '0;
            tick_nxt = 1'b1;
        end
        else
        begin
            bcnt_nxt = bcnt_r + 14'h1;
        end
    end

    // settings registers, defaults until the first record
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            xchg_en_r <= dcs_pkg::XCHG_EN_RST;
            baud_r    <= dcs_pkg::BAUD_RST;
            div_r     <= dcs_pkg::baud_div(dcs_pkg::BAUD_RST);
            bcnt_r    <= '0;
            tick_r    <= 1'b0;
        end
        else
        begin
            xchg_en_r <= xchg_en_nxt;
            baud_r    <= baud_nxt;
            div_r     <= div_nxt;
            bcnt_r    <= bcnt_nxt;
            tick_r    <= tick_nxt;
        end
    end

    // internal door state tracking
    always_comb
    begin
        door_nxt = door_r;
        unique case (door_r)
            dcs_pkg::DOOR_BETWEEN:
            begin
                if (close_reached_i)
                begin
                    door_nxt = dcs_pkg::DOOR_CLOSED;     // drive order only
                end
                else if (open_pos_i)
                begin
                    door_nxt = dcs_pkg::DOOR_OPEN;       // by drive or pushing
                end
            end
            dcs_pkg::DOOR_CLOSED:
            begin
                if (drive_start_i || push_i)
                begin
                    door_nxt = dcs_pkg::DOOR_BETWEEN;
                end
            end
            dcs_pkg::DOOR_OPEN:
            begin
                if (drive_start_i || (push_i && !open_pos_i))
                begin
                    door_nxt = dcs_pkg::DOOR_BETWEEN;
                end
            end
            default:
            begin
                door_nxt = dcs_pkg::DOOR_BETWEEN;
            end
        endcase
    end

    // relay drive from state and sensor test
    always_comb
    begin
        rly_cl_nxt = (door_nxt == dcs_pkg::DOOR_CLOSED);
        rly_op_nxt = (door_nxt == dcs_pkg::DOOR_OPEN);
        if (sensor_test_active_i)
        begin
            // configuration decides what the test puts out
            unique case (sensor_config_parameter_i)
                dcs_pkg::SCFG_NONE:
                begin
                    rly_cl_nxt = (door_nxt == dcs_pkg::DOOR_CLOSED);
                end
                dcs_pkg::SCFG_INVERT:
                begin
                    rly_cl_nxt = !sensor_test_output_i;
                end
                default:
                begin
                    rly_cl_nxt = sensor_test_output_i;
                end
            endcase
        end
    end

    // door state and relay registers
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            door_r   <= dcs_pkg::DOOR_BETWEEN;
            rly_cl_r <= 1'b0;
            rly_op_r <= 1'b0;
        end
        else
        begin
            door_r   <= door_nxt;
            rly_cl_r <= rly_cl_nxt;
            rly_op_r <= rly_op_nxt;
        end
    end

    // outputs straight from flip-flops
    assign rec_done_o        = done_r;
    assign rec_error_o       = err_r;
    assign bus_exchange_en_o = xchg_en_r;
    assign baud_code_o       = baud_r;
    assign baud_div_o        = div_r;
    assign baud_tick_o       = tick_r;
    assign relay_closed_o    = rly_cl_r;
    assign relay_open_o      = rly_op_r;

endmodule : dcs_door_comm
`default_nettype wire

// File: dcs_door_comm_properties.sv
// port checker for dcs_door_comm
// assumes one clock and srst_i synchronous active high
`timescale 1ns/1ps
`default_nettype none
module dcs_chk
(
    // clock, reset, inputs
    input wire logic                      clk_i,
    input wire logic                      srst_i,
    input wire logic                      rec_start_i,
    input wire logic                      rec_valid_i,
    input wire logic                      drive_start_i,
    input wire logic                      close_reached_i,
    input wire logic                      push_i,
    input wire logic                      open_pos_i,
    input wire logic                      sensor_test_active_i,
    input wire logic                      sensor_test_output_i,
    input wire logic [1:0]                sensor_config_parameter_i,
    // outputs
    input wire logic                      rec_done_o,
    input wire logic                      bus_exchange_en_o,
    input wire logic [3:0]                baud_code_o,
    input wire logic [dcs_pkg::DIV_W-1:0] baud_div_o,
    input wire logic                      baud_tick_o,
    input wire logic                      relay_closed_o,
    input wire logic                      relay_open_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // record start then eight back to back bytes
    sequence s_rec;
        rec_start_i ##1 (rec_valid_i && !rec_start_i)[*8];
    endsequence
    property p_rec_walk;
        s_rec |=> ##2 rec_done_o;
    endproperty
    a_rec_walk: assert property (p_rec_walk) else $error("record not applied in time");

    // defaults during and after reset
    property p_rst_dflt;
        @(posedge clk_i) disable iff (1'h0)
        srst_i |=> bus_exchange_en_o && baud_code_o == 4'h4 && !rec_done_o;
    endproperty
    a_rst_dflt: assert property (p_rst_dflt) else $error("reset defaults wrong");

    // settings move only with an applied record
    property p_hold;
        ($changed(baud_code_o) || $changed(bus_exchange_en_o)) && !$past(srst_i) |-> rec_done_o;
    endproperty
    a_hold: assert property (p_hold) else $error("settings changed without record");

    // rate code range and slowest divisor
    property p_code_max;
        baud_code_o <= 4'ha;
    endproperty
    a_code_max: assert property (p_code_max) else $error("baud code out of range");
    property p_div;
        baud_code_o == 4'h0 |-> baud_div_o == 14'h28b1;
    endproperty
    a_div: assert property (p_div) else $error("divisor wrong for code 0");

    // no bus timing while exchange is off
    property p_no_tick;
        !bus_exchange_en_o && !$past(bus_exchange_en_o) |-> !baud_tick_o;
    endproperty
    a_no_tick: assert property (p_no_tick) else $error("tick while disabled");

    // closed relay rises only from a drive order outside test
    property p_closed_entry;
        $rose(relay_closed_o) && !$past(sensor_test_active_i) && !$past(sensor_test_active_i, 2)
            |-> $past(close_reached_i);
    endproperty
    a_closed_entry: assert property (p_closed_entry) else $error("closed without drive");

    // pushing leaves the closed state
    property p_push_leaves;
        relay_closed_o && push_i && !close_reached_i && !sensor_test_active_i |=> !relay_closed_o;
    endproperty
    a_push_leaves: assert property (p_push_leaves) else $error("push kept closed");

    // drive or push away from the open position leaves the open state
    property p_open_leave;
        relay_open_o && (push_i || drive_start_i) && !open_pos_i |=> !relay_open_o;
    endproperty
    a_open_leave: assert property (p_open_leave) else $error("open state kept");

    // sensor test steers the closed relay
    property p_test_direct;
        sensor_test_active_i && sensor_config_parameter_i == 2'h1
            |=> relay_closed_o == $past(sensor_test_output_i);
    endproperty
    a_test_direct: assert property (p_test_direct) else $error("test not passed");
    property p_test_inv;
        sensor_test_active_i && sensor_config_parameter_i == 2'h2
            |=> relay_closed_o != $past(sensor_test_output_i);
    endproperty
    a_test_inv: assert property (p_test_inv) else $error("test not inverted");
endmodule : dcs_chk

bind dcs_door_comm dcs_chk dcs_chk_inst (.clk_i, .srst_i, .rec_start_i, .rec_valid_i,
    .drive_start_i, .close_reached_i, .push_i, .open_pos_i, .sensor_test_active_i,
    .sensor_test_output_i, .sensor_config_parameter_i, .rec_done_o, .bus_exchange_en_o,
    .baud_code_o, .baud_div_o, .baud_tick_o, .relay_closed_o, .relay_open_o);
`default_nettype wire

// File: dcs_door_comm_tb.sv
// self-checking bench for dcs_door_comm
// assumes the controller model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module dcs_door_comm_tb;
    // design connections
    logic        clk_i;
    logic        srst_i;
    logic        rec_start_i;
    logic        rec_valid_i;
    logic [7:0]  rec_data_i;
    logic        rec_done_o;
    logic        rec_error_o;
    logic        bus_exchange_en_o;
    logic [3:0]  baud_code_o;
    logic [13:0] baud_div_o;
    logic        baud_tick_o;
    logic [3:0]  door;
    logic [1:0]  cfg;
    logic        tst_act;
    logic        tst_out;
    logic        relay_closed_o;
    logic        relay_open_o;
    int          n_mismatch;
    int          cmp_count;
    // clock cycles per bit for codes 0 to 10, nearest whole cycle at 100 MHz
    int          divs [11] = '{10417, 5208, 2604, 1736, 868, 533, 400, 333, 267, 200, 133};

    // design and far side
    dcs_ctrl_model dcs_ctrl_model_inst (.clk_i, .rec_start_o(rec_start_i),
        .rec_valid_o(rec_valid_i), .rec_data_o(rec_data_i));
    dcs_door_comm dcs_door_comm_inst (.clk_i, .srst_i, .rec_start_i, .rec_valid_i, .rec_data_i,
        .rec_done_o, .rec_error_o, .bus_exchange_en_o, .baud_code_o, .baud_div_o, .baud_tick_o,
        .drive_start_i(door[3]), .close_reached_i(door[2]), .push_i(door[1]),
        .open_pos_i(door[0]), .sensor_test_active_i(tst_act), .sensor_test_output_i(tst_out),
        .sensor_config_parameter_i(cfg), .relay_closed_o, .relay_open_o);

    // clock
    initial
    begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    // send one record and time the applied pulse
    task automatic rec(input logic [7:0] b0, input int gap, input logic err);
        int n;
        n = 0;
        dcs_ctrl_model_inst.send_rec(b0, gap);
        do
        begin
            @(posedge clk_i) #1;
            n++;
        end while (rec_done_o !== 1'h1 && n < 8);
        chk(n, 2);
        chk(rec_error_o, err);
    endtask : rec

    task automatic t_rates;
        int n;
        for (int c = 0; c < 11; c++)
        begin
            rec({3'h0, 4'(c), ~c[0]}, c % 3, 1'h0);
            chk(bus_exchange_en_o, !c[0]);
            chk(baud_code_o, c);
            chk(baud_div_o, divs[c]);
        end
        n = 0;
        while (baud_tick_o !== 1'h1 && n < 300)
        begin
            @(posedge clk_i) #1;
            n++;
        end
        n = 0;
        do
        begin
            @(posedge clk_i) #1;
            n++;
        end while (baud_tick_o !== 1'h1 && n < 300);
        chk(n, 133);
        rec({3'h7, 4'hb, 1'h0}, 0, 1'h1);
        chk(baud_code_o, 4'ha);
        chk(bus_exchange_en_o, 1'h0);
    endtask : t_rates

    // record cut short by a new start, then a mid-run reset back to defaults
    task automatic t_abort;
        dcs_ctrl_model_inst.send_cut(3);
        chk(rec_error_o, 1'h1);
        rec(8'h05, 0, 1'h0);
        chk(baud_code_o, 4'h2);
        chk(bus_exchange_en_o, 1'h1);
        @(posedge clk_i) #1;
        srst_i = 1'h1;
        @(posedge clk_i) #1;
        srst_i = 1'h0;
        chk(bus_exchange_en_o, 1'h1);
        chk(baud_code_o, 4'h4);
        chk(baud_div_o, 14'h364);
        @(posedge clk_i) #1;
        chk({rec_done_o, rec_error_o}, 2'h0);
    endtask : t_abort

    // one door event for a cycle, then relays settled
    task automatic drv(input logic [3:0] v, input logic cl, input logic op);
        @(posedge clk_i) #1;
        door = v;
        @(posedge clk_i) #1;
        door = 4'h0;
        chk(relay_closed_o, cl);
        chk(relay_open_o, op);
    endtask : drv

    task automatic t_door;
        logic [4:0] tv [7] = '{5'h12, 5'h1b, 5'h1c, 5'h15, 5'h11, 5'h16, 5'h03};
        drv(4'h2, 1'h0, 1'h0);
        drv(4'h4, 1'h1, 1'h0);
        drv(4'h2, 1'h0, 1'h0);
        drv(4'h4, 1'h1, 1'h0);
        drv(4'h8, 1'h0, 1'h0);
        drv(4'h1, 1'h0, 1'h1);
        drv(4'h2, 1'h0, 1'h0);
        drv(4'h3, 1'h0, 1'h1);
        drv(4'h8, 1'h0, 1'h0);
        drv(4'h4, 1'h1, 1'h0);
        // test entries: active, output, config, expected closed relay
        foreach (tv[i])
        begin
            @(posedge clk_i) #1;
            {tst_act, tst_out, cfg} = tv[i][4:1];
            @(posedge clk_i) #1;
            chk(relay_closed_o, tv[i][0]);
        end
    endtask : t_door

    // watchdog
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        give_verdict;
    end

    // reset then scenarios
    initial
    begin
        n_mismatch = 0;
        cmp_count  = 0;
        srst_i     = 1'h1;
        door       = 4'h0;
        {tst_act, tst_out, cfg} = 4'h0;
        repeat (10) @(posedge clk_i);
        #1;
        srst_i = 1'h0;
        chk(bus_exchange_en_o, 1'h1);
        chk(baud_div_o, 14'h364);
        chk({relay_closed_o, relay_open_o}, 2'h0);
        t_rates;
        t_abort;
        t_door;
        give_verdict;
    end
endmodule : dcs_door_comm_tb
`default_nettype wire

// File: dcs_pkg.sv
// constants, encodings and decode helpers for the door communication block
// assumes a single 100 MHz clock and a byte-wide startup record port
package dcs_pkg;

    // clock rate
    localparam int unsigned CLK_HZ       = 100_000_000;

    // startup record layout
    localparam int unsigned REC_BYTES    = 8;
    localparam int unsigned REC_AW       = 3;
    localparam logic [2:0]  REC_LAST_IDX = 3'h7;
    localparam logic [2:0]  REC_CFG_IDX  = 3'h0;   // byte 1 of the record

    // fields of the bus exchange and rate setting byte
    localparam int unsigned XCHG_EN_BIT  = 0;
    localparam int unsigned BAUD_LSB     = 1;
    localparam int unsigned BAUD_MSB     = 4;

    // values after reset and until the first record
    localparam logic        XCHG_EN_RST  = 1'b1;
    localparam logic [3:0]  BAUD_RST     = 4'h4;   // 115200
    localparam logic [3:0]  BAUD_MAX     = 4'ha;   // highest legal code

    // baud rates selected by codes 0000 to 1010
    localparam int unsigned BAUD_0  = 9600;
    localparam int unsigned BAUD_1  = 19200;
    localparam int unsigned BAUD_2  = 38400;
    localparam int unsigned BAUD_3  = 57600;
    localparam int unsigned BAUD_4  = 115200;
    localparam int unsigned BAUD_5  = 187500;
    localparam int unsigned BAUD_6  = 250000;
    localparam int unsigned BAUD_7  = 300000;
    localparam int unsigned BAUD_8  = 375000;
    localparam int unsigned BAUD_9  = 500000;
    localparam int unsigned BAUD_10 = 750000;

    // divider width, enough for the slowest rate
    localparam int unsigned DIV_W   = 14;

    // sensor configuration codes steering the closed relay in test
    localparam logic [1:0]  SCFG_NONE   = 2'h0;    // no sensor, test ignored
    localparam logic [1:0]  SCFG_DIRECT = 2'h1;    // test signal passed through
    localparam logic [1:0]  SCFG_INVERT = 2'h2;    // test signal inverted

    // record intake states
    typedef enum logic [1:0] {REC_IDLE, REC_FILL, REC_READ, REC_APPLY} dcs_rec_state_t;

    // internal door states
    typedef enum logic [1:0] {DOOR_BETWEEN, DOOR_CLOSED, DOOR_OPEN} dcs_door_state_t;

    // clock cycles per bit, rounded to nearest
    function automatic logic [DIV_W-1:0] baud_div(input logic [3:0] code);
        int unsigned b;
        b = BAUD_4;
        unique case (code)
            4'h0:    b = BAUD_0;
            4'h1:    b = BAUD_1;
            4'h2:    b = BAUD_2;
            4'h3:    b = BAUD_3;
            4'h4:    b = BAUD_4;
            4'h5:    b = BAUD_5;
            4'h6:    b = BAUD_6;
            4'h7:    b = BAUD_7;
            4'h8:    b = BAUD_8;
            4'h9:    b = BAUD_9;
            4'ha:    b = BAUD_10;
            default: b = BAUD_4;
        endcase
        return DIV_W'((CLK_HZ + b / 2) / b);
    endfunction : baud_div

endpackage : dcs_pkg

// File: dcs_rec_mem.sv
// small byte store holding one startup record
// assumes one clock, one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none
module dcs_rec_mem
(
    // clock
    input  wire logic                        clk_i,
    // write side
    input  wire logic                        wr_en_i,
    input  wire logic [dcs_pkg::REC_AW-1:0]  wr_addr_i,
    input  wire logic [7:0]                  wr_data_i,
    // read side
    input  wire logic [dcs_pkg::REC_AW-1:0]  rd_addr_i,
    output logic      [7:0]                  rd_data_o
);

    logic [7:0] mem_r [dcs_pkg::REC_BYTES];
    logic [7:0] rd_data_r;

    // byte store and registered read
    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
        rd_data_r <= mem_r[rd_addr_i];
    end

    assign rd_data_o = rd_data_r;

endmodule : dcs_rec_mem
`default_nettype wire
